/* include/exec_pkg.sv */
// Shared constants for the add, AND, bit and branch execution slice.
// Assumes an 8-bit core with a four-phase instruction cycle on sys_clk.
//
// Summary of operation
// - Add-with-carry sums work, file and carry; d picks work or file.
// - Bank bit 0 selects the access bank, 1 the bank select register.
// - Bank bit 0, extended set on and address up to 95: indexed offset.
// - AND literal: work AND immediate into work, only N and Z change.
// - AND file: work AND file to the d destination, only N and Z change.
// - Bit clear zeroes one chosen file bit, no flags, one cycle.
// - Bit set forces one chosen file bit high, no flags, one cycle.
// - Taken branch loads counter plus two plus twice the signed offset.
// - Conditional branch: one cycle when false, two when taken.
// - Negative branches: high byte E6 when N set, E7 when N clear.
// - Carry branches: E2 when carry set, E3 when clear; flags untouched.
// - Zero branches: E0 when Z set, E1 when Z clear.
// - Overflow branches: E4 when overflow set, E5 when clear.
// - Unconditional branch, bits 11010 plus 11-bit offset, two cycles.
package exec_pkg;
   typedef enum logic [1:0] {
      ph_decode,
      ph_read,
      ph_process,
      ph_write
   } phase_e;

   typedef enum logic [2:0] {
      alu_pass,
      alu_add_carry,
      alu_and,
      alu_clr,
      alu_set
   } alu_op_e;

   // Opcode fields, compared against the top bits of the word
   localparam logic [5:0] OP_ADD_CARRY = 6'h08;
   localparam logic [5:0] OP_AND_FILE = 6'h05;
   localparam logic [7:0] OP_AND_LIT = 8'h0B;
   localparam logic [3:0] OP_BIT_CLR = 4'h9;
   localparam logic [3:0] OP_BIT_SET = 4'h8;
   localparam logic [4:0] OP_COND_BR = 5'h1C;
   localparam logic [4:0] OP_JUMP_REL = 5'h1A;

   // Field positions inside the instruction word
   localparam int D_BIT = 9;
   localparam int A_BIT = 8;
   localparam int BIT_MSB = 11;
   localparam int BIT_LSB = 9;
   localparam int CC_MSB = 10;
   localparam int CC_LSB = 8;
   localparam int F_MSB = 7;
   localparam int JMP_MSB = 10;

   // Condition groups, cc[2:1]; cc[0] set means branch on flag clear
   localparam logic [1:0] CC_ZERO = 2'h0;
   localparam logic [1:0] CC_CARRY = 2'h1;
   localparam logic [1:0] CC_OVF = 2'h2;
   localparam logic [1:0] CC_NEG = 2'h3;

   // Data memory addressing
   localparam int FILE_AW = 12;
   localparam logic [7:0] ACCESS_SPLIT = 8'h80;
   localparam logic [3:0] ACCESS_LO = 4'h0;
   localparam logic [3:0] ACCESS_HI = 4'hF;
   localparam logic [7:0] INDEX_MAX = 8'h5F;

   // Status flag positions
   localparam int STATUS_W = 5;
   localparam int FL_C = 0;
   localparam int FL_DC = 1;
   localparam int FL_Z = 2;
   localparam int FL_OV = 3;
   localparam int FL_N = 4;

   // Register port map, 8-bit data
   localparam logic [3:0] REG_CTRL = 4'h0;
   localparam logic [3:0] REG_BANK = 4'h1;
   localparam logic [3:0] REG_WORK = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_PC_LO = 4'h4;
   localparam logic [3:0] REG_PC_MID = 4'h5;
   localparam logic [3:0] REG_PC_UP = 4'h6;
   localparam logic [3:0] REG_INSTR_LO = 4'h7;
   localparam logic [3:0] REG_INSTR_HI = 4'h8;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_EXT = 1;
   localparam int CTRL_FLUSH = 2;

   // Reset values and steps
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [15:0] RST_INSTR = 16'h0000;
   localparam int PC_STEP = 2;
endpackage

/* rtl/byte_alu.sv */
// Byte datapath for add with carry, AND and single bit clear or set.
// Assumes operands are stable for the cycle the result is captured.
module byte_alu
   import exec_pkg::*;
(
   // Operation
   input wire alu_op_e op,
   input wire logic [7:0] a,
   input wire logic [7:0] b,
   input wire logic cin,
   input wire logic [2:0] bit_pos,
   // Result
   output logic [7:0] res,
   output logic c,
   output logic dc,
   output logic ov
);
   logic [4:0] nib_sum;
   logic [7:0] bit_mask;

   assign nib_sum = 5'(a[3:0]) + 5'(b[3:0]) + 5'(cin);
   assign bit_mask = 8'h01 << bit_pos;

   always_comb begin
      res = b;
      c = 1'b0;
      dc = 1'b0;
      ov = 1'b0;
      case (op)
         alu_add_carry: begin
            {c, res} = 9'(a) + 9'(b) + 9'(cin);
            dc = nib_sum[4];
            ov = (a[7] == b[7]) && (res[7] != a[7]);
         end
         alu_and: res = a & b;
         alu_clr: res = b & ~bit_mask;
         alu_set: res = b | bit_mask;
         default: res = b;
      endcase
   end
endmodule

/* rtl/cpu_add_and_bit_branch_exec.sv */
// Execution slice: add with carry, AND, bit clear/set, relative branches.
// Assumes program memory answers in the decode phase and data memory
// returns read data one sys_clk after its read strobe.
//
// Added by the designer: the address map and the plain strobed port.
module cpu_add_and_bit_branch_exec
   import exec_pkg::*;
#(
   parameter int PC_W = 21,
   parameter int BANK_W = 4
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Register port
   input wire logic [3:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   // Program memory
   output logic [PC_W-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   // Data memory
   output logic [FILE_AW-1:0] file_addr,
   output logic file_re,
   input wire logic [7:0] file_rdata,
   output logic file_we,
   output logic [7:0] file_wdata,
   input wire logic [FILE_AW-1:0] idx_base
);
   phase_e phase;
   phase_e next_phase;
   logic run;
   logic ext_en;
   logic flush;
   logic exec;
   logic [15:0] instr;
   logic [7:0] work;
   logic [STATUS_W-1:0] status;
   logic [BANK_W-1:0] bank_select_reg;
   logic [PC_W-1:0] pc;
   logic [7:0] result;
   logic res_c;
   logic res_dc;
   logic res_ov;

   // Decode
   logic is_add_carry;
   logic is_and_file;
   logic is_and_lit;
   logic is_bit_clr;
   logic is_bit_set;
   logic is_cond_br;
   logic is_jump_rel;
   logic uses_file;
   logic dest_file;
   logic dest_work;
   logic flag_bit;
   logic taken;
   logic jump;
   logic [2:0] cc;
   alu_op_e alu_op;
   logic [7:0] alu_b;
   logic [7:0] alu_res;
   logic alu_c;
   logic alu_dc;
   logic alu_ov;
   logic [PC_W-1:0] rel_off;
   logic [PC_W-1:0] branch_target;
   logic [PC_W-1:0] next_pc;
   logic [7:0] fetch_f;
   logic [FILE_AW-1:0] next_file_addr;
   logic [23:0] pc_wide;
   logic [7:0] next_rdata;

   logic ctrl_run;
   assign run = ctrl_run;

   assign exec = !flush;
   assign cc = instr[CC_MSB:CC_LSB];
   assign is_add_carry = instr[15:10] == OP_ADD_CARRY;
   assign is_and_file = instr[15:10] == OP_AND_FILE;
   assign is_and_lit = instr[15:8] == OP_AND_LIT;
   assign is_bit_clr = instr[15:12] == OP_BIT_CLR;
   assign is_bit_set = instr[15:12] == OP_BIT_SET;
   assign is_cond_br = instr[15:11] == OP_COND_BR;
   assign is_jump_rel = instr[15:11] == OP_JUMP_REL;
   assign uses_file = is_add_carry | is_and_file | is_bit_clr | is_bit_set;
   // d selects work (0) or file (1) for add and AND with file
   assign dest_file = ((is_add_carry | is_and_file) & instr[D_BIT])
      | is_bit_clr | is_bit_set;
   assign dest_work = ((is_add_carry | is_and_file) & !instr[D_BIT])
      | is_and_lit;

   // Flag under test; low cc bit inverts the sense
   always_comb begin
      case (cc[2:1])
         CC_ZERO: flag_bit = status[FL_Z];
         CC_CARRY: flag_bit = status[FL_C];
         CC_OVF: flag_bit = status[FL_OV];
         CC_NEG: flag_bit = status[FL_N];
         default: flag_bit = 1'b0;
      endcase
   end

   assign taken = is_cond_br & (flag_bit ^ cc[0]);
   assign jump = taken | is_jump_rel;

   // Offset is in words, so it is doubled onto the byte counter
   assign rel_off = is_cond_br
      ? {{(PC_W-8){instr[F_MSB]}}, instr[F_MSB:0]}
      : {{(PC_W-11){instr[JMP_MSB]}}, instr[JMP_MSB:0]};
   assign branch_target = pc + PC_W'(PC_STEP) + (rel_off << 1);
   assign next_pc = jump ? branch_target : pc + PC_W'(PC_STEP);

   always_comb begin
      case (phase)
         ph_decode: next_phase = ph_read;
         ph_read: next_phase = ph_process;
         ph_process: next_phase = ph_write;
         ph_write: next_phase = ph_decode;
         default: next_phase = ph_decode;
      endcase
   end

   // A started instruction always finishes even if run drops
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         phase <= ph_decode;
      end else if (run || phase != ph_decode) begin
         phase <= next_phase;
      end
   end

   // Operand address is formed while the word is fetched
   assign fetch_f = prog_data[F_MSB:0];
   always_comb begin
      if (!prog_data[A_BIT] && ext_en && fetch_f <= INDEX_MAX) begin
         next_file_addr = idx_base + FILE_AW'(fetch_f);
      end else if (!prog_data[A_BIT]) begin
         next_file_addr = {(fetch_f >= ACCESS_SPLIT) ? ACCESS_HI
            : ACCESS_LO, fetch_f};
      end else begin
         next_file_addr = FILE_AW'({bank_select_reg, fetch_f});
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         instr <= RST_INSTR;
         file_addr <= '0;
      end else if (phase == ph_decode && run) begin
         instr <= prog_data;
         file_addr <= next_file_addr;
      end
   end

   assign prog_addr = pc;
   assign file_re = phase == ph_read && exec && uses_file;
   assign file_we = phase == ph_write && exec && dest_file;

   always_comb begin
      if (is_add_carry) begin
         alu_op = alu_add_carry;
      end else if (is_and_file || is_and_lit) begin
         alu_op = alu_and;
      end else if (is_bit_clr) begin
         alu_op = alu_clr;
      end else if (is_bit_set) begin
         alu_op = alu_set;
      end else begin
         alu_op = alu_pass;
      end
   end
   assign alu_b = is_and_lit ? instr[F_MSB:0] : file_rdata;

   byte_alu u_alu (
      .op(alu_op),
      .a(work),
      .b(alu_b),
      .cin(status[FL_C]),
      .bit_pos(instr[BIT_MSB:BIT_LSB]),
      .res(alu_res),
      .c(alu_c),
      .dc(alu_dc),
      .ov(alu_ov)
   );

   // Read data lands in the process phase and is captured there
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         result <= RST_BYTE;
         res_c <= 1'b0;
         res_dc <= 1'b0;
         res_ov <= 1'b0;
      end else if (phase == ph_process) begin
         result <= alu_res;
         res_c <= alu_c;
         res_dc <= alu_dc;
         res_ov <= alu_ov;
      end
   end
   assign file_wdata = result;

   // Set at the write phase of a jump, cleared at the next write phase four cycles later
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         flush <= 1'b0;
      end else if (phase == ph_write) begin
         flush <= exec && jump;
      end
   end

   // Core write wins over a register-port write in the same cycle
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         pc <= '0;
      end else if (phase == ph_write && exec) begin
         pc <= next_pc;
      end else if (reg_wr && reg_addr == REG_PC_LO) begin
         pc[7:0] <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_PC_MID) begin
         pc[15:8] <= reg_wdata;
      end else if (reg_wr && reg_addr == REG_PC_UP) begin
         pc[PC_W-1:16] <= reg_wdata[PC_W-17:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         work <= RST_BYTE;
      end else if (phase == ph_write && exec && dest_work) begin
         work <= result;
      end else if (reg_wr && reg_addr == REG_WORK) begin
         work <= reg_wdata;
      end
   end

   // Bit ops and branches leave every flag alone
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         status <= '0;
      end else if (phase == ph_write && exec && is_add_carry) begin
         status[FL_C] <= res_c;
         status[FL_DC] <= res_dc;
         status[FL_OV] <= res_ov;
         status[FL_Z] <= result == RST_BYTE;
         status[FL_N] <= result[7];
      end else if (phase == ph_write && exec
            && (is_and_file || is_and_lit)) begin
         status[FL_Z] <= result == RST_BYTE;
         status[FL_N] <= result[7];
      end else if (reg_wr && reg_addr == REG_STATUS) begin
         status <= reg_wdata[STATUS_W-1:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         ctrl_run <= 1'b0;
         ext_en <= 1'b0;
         bank_select_reg <= '0;
      end else if (reg_wr && reg_addr == REG_CTRL) begin
         ctrl_run <= reg_wdata[CTRL_RUN];
         ext_en <= reg_wdata[CTRL_EXT];
      end else if (reg_wr && reg_addr == REG_BANK) begin
         bank_select_reg <= reg_wdata[BANK_W-1:0];
      end
   end

   assign pc_wide = 24'(pc);
   always_comb begin
      case (reg_addr)
         REG_CTRL: begin
            next_rdata = RST_BYTE;
            next_rdata[CTRL_RUN] = ctrl_run;
            next_rdata[CTRL_EXT] = ext_en;
            next_rdata[CTRL_FLUSH] = flush;
         end
         REG_BANK: next_rdata = 8'(bank_select_reg);
         REG_WORK: next_rdata = work;
         REG_STATUS: next_rdata = 8'(status);
         REG_PC_LO: next_rdata = pc_wide[7:0];
         REG_PC_MID: next_rdata = pc_wide[15:8];
         REG_PC_UP: next_rdata = pc_wide[23:16];
         REG_INSTR_LO: next_rdata = instr[7:0];
         REG_INSTR_HI: next_rdata = instr[15:8];
         default: next_rdata = RST_BYTE;
      endcase
   end

   // Read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         reg_rdata <= RST_BYTE;
      end else begin
         reg_rdata <= reg_rd ? next_rdata : RST_BYTE;
      end
   end

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   chk_add_carry_sum:
      assert property (phase == ph_process && exec && is_add_carry
         |=> result == 8'($past(work) + $past(file_rdata)
            + 8'($past(status[FL_C]))))
      else $error("add with carry result wrong");

   chk_bank_addr:
      assert property (phase == ph_decode && run && prog_data[A_BIT]
         |=> file_addr == FILE_AW'({$past(bank_select_reg),
            $past(prog_data[F_MSB:0])}))
      else $error("banked file address wrong");

   chk_indexed_addr:
      assert property (phase == ph_decode && run && !prog_data[A_BIT]
         && ext_en && prog_data[F_MSB:0] <= INDEX_MAX
         |=> file_addr == $past(idx_base)
            + FILE_AW'($past(prog_data[F_MSB:0])))
      else $error("indexed offset address wrong");

   chk_and_literal:
      assert property (phase == ph_process && exec && is_and_lit
         |=> result == ($past(work) & $past(instr[F_MSB:0]))
         ##1 work == $past(result) && status[FL_C] == $past(status[FL_C])
            && status[FL_OV] == $past(status[FL_OV]))
      else $error("literal AND wrong or touched C/OV");

   chk_and_file_flags:
      assert property (phase == ph_write && exec && is_and_file
         |=> status[FL_C] == $past(status[FL_C])
            && status[FL_DC] == $past(status[FL_DC])
            && status[FL_Z] == ($past(result) == RST_BYTE))
      else $error("file AND flags wrong");

   chk_bit_clear:
      assert property (file_we && is_bit_clr
         |-> !file_wdata[instr[BIT_MSB:BIT_LSB]]
         ##1 status == $past(status))
      else $error("bit clear failed or changed flags");

   chk_bit_set:
      assert property (file_we && is_bit_set
         |-> file_wdata[instr[BIT_MSB:BIT_LSB]]
         ##1 status == $past(status))
      else $error("bit set failed or changed flags");

   chk_branch_target:
      assert property (phase == ph_write && exec && jump
         |=> pc == $past(pc) + PC_W'(PC_STEP) + ($past(rel_off) << 1))
      else $error("branch target wrong");

   chk_not_taken:
      assert property (phase == ph_write && exec && is_cond_br && !taken
         |=> !flush && pc == $past(pc) + PC_W'(PC_STEP))
      else $error("untaken branch cost a cycle");

   chk_taken_flush:
      assert property (phase == ph_write && exec && jump
         |=> flush && phase == ph_decode ##1 flush)
      else $error("taken branch not two cycles");

   chk_cond_sense:
      assert property (is_cond_br && cc == {CC_CARRY, 1'b0}
         |-> taken == status[FL_C])
      else $error("carry branch sense wrong");

   chk_flush_quiet:
      assert property (flush |-> !file_we && !file_re
         ##1 work == $past(work))
      else $error("write during flushed cycle");

   chk_phase_order:
      assert property (phase == ph_read
         |=> phase == ph_process ##1 phase == ph_write
         ##1 phase == ph_decode)
      else $error("phase order broken");

   cov_taken: cover property (phase == ph_write && exec && taken);
   cov_untaken: cover property (phase == ph_write && exec
      && is_cond_br && !taken);
   cov_add_to_file: cover property (file_we && is_add_carry);
   cov_indexed: cover property (phase == ph_decode && run && ext_en
      && !prog_data[A_BIT] && prog_data[F_MSB:0] <= INDEX_MAX);
endmodule

/* test/mem_model.sv */
// Program memory and banked data memory beside the execution slice.
// Assumes one sys_clk domain; read data follow the read strobe by a cycle.
module mem_model
   import exec_pkg::*;
#(
   parameter int PC_W = 21
) (
   // Clock
   input wire logic sys_clk,
   // Program side
   input wire logic [PC_W-1:0] prog_addr,
   output logic [15:0] prog_data,
   // Data side
   input wire logic [FILE_AW-1:0] file_addr,
   input wire logic file_re,
   input wire logic file_we,
   input wire logic [7:0] file_wdata,
   output logic [7:0] file_rdata
);
   logic [15:0] prog [256];
   logic [7:0] ram [4096];

   initial begin
      file_rdata = 8'h00;
      foreach (prog[i]) prog[i] = 16'h0000;
      foreach (ram[i]) ram[i] = 8'h00;
   end

   assign prog_data = prog[prog_addr[8:1]];

   // Outside a read the bus toggles, so a late sample reads garbage
   always @(posedge sys_clk) begin
      if (file_re)
         file_rdata <= ram[file_addr];
      else
         file_rdata <= ~file_rdata;
      if (file_we)
         ram[file_addr] <= file_wdata;
   end
endmodule

/* test/cpu_add_and_bit_branch_exec_tb.sv */
// Self-checking bench for the add, AND, bit and branch execution slice.
// Assumes mem_model for both memories; the core is started and stopped
// over the register port after a known count of instruction cycles.
module cpu_add_and_bit_branch_exec_tb
   import exec_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   logic sys_clk;
   logic resetn;
   logic [3:0] reg_addr;
   logic [7:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [7:0] reg_rdata;
   logic [20:0] prog_addr;
   logic [15:0] prog_data;
   logic [FILE_AW-1:0] file_addr;
   logic file_re;
   logic [7:0] file_rdata;
   logic file_we;
   logic [7:0] file_wdata;
   logic [FILE_AW-1:0] idx_base;
   logic [7:0] ext;
   logic watch;
   int n_errors = 0;
   int n_compared = 0;
   int cycles = 0;
   int re_seen;
   int we_seen;

   cpu_add_and_bit_branch_exec #(.PC_W(21), .BANK_W(4)) u_dut (
      .sys_clk(sys_clk), .resetn(resetn), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .prog_addr(prog_addr),
      .prog_data(prog_data), .file_addr(file_addr), .file_re(file_re),
      .file_rdata(file_rdata), .file_we(file_we),
      .file_wdata(file_wdata), .idx_base(idx_base)
   );

   mem_model #(.PC_W(21)) u_mem (
      .sys_clk(sys_clk), .prog_addr(prog_addr), .prog_data(prog_data),
      .file_addr(file_addr), .file_re(file_re), .file_we(file_we),
      .file_wdata(file_wdata), .file_rdata(file_rdata)
   );

   initial begin
      sys_clk = 1'b0;
      forever #2 sys_clk = ~sys_clk;
   end

   // A hang in any scenario still ends in the closing report
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         n_errors++;
         summarize();
      end
      if (watch && file_re === 1'b1)
         re_seen++;
      if (watch && file_we === 1'b1)
         we_seen++;
   end

   task automatic summarize();
      $display("compared %0d, errors %0d", n_compared, n_errors);
      if (n_errors == 0 && n_compared > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic rd(input logic [3:0] a, input logic [7:0] exp,
                     input string what);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1;
      check(what, exp, reg_rdata);
   endtask

   task automatic check_pc(input logic [20:0] exp);
      rd(REG_PC_LO, exp[7:0], "pc low");
      rd(REG_PC_MID, exp[15:8], "pc middle");
      rd(REG_PC_UP, {3'b000, exp[20:16]}, "pc upper");
   endtask

   // Stop lands mid-instruction so a one-edge start skew is tolerated
   task automatic run(input logic [20:0] pc0, input int k);
      wr(REG_PC_LO, pc0[7:0]);
      wr(REG_PC_MID, pc0[15:8]);
      wr(REG_PC_UP, {3'b000, pc0[20:16]});
      re_seen = 0;
      we_seen = 0;
      watch = 1'b1;
      wr(REG_CTRL, ext | 8'h01);
      repeat (4 * k - 3) @(posedge sys_clk);
      wr(REG_CTRL, ext);
      repeat (3) @(posedge sys_clk);
      watch = 1'b0;
   endtask

   task automatic t_reset();
      for (int a = 0; a < 16; a++) begin
         rd(4'(a), 8'h00, "reset or unmapped register");
      end
      wr(4'hC, 8'hFF);
      rd(4'hC, 8'h00, "unmapped register");
      wr(REG_CTRL, 8'h04);
      rd(REG_CTRL, 8'h00, "read-only flush bit");
   endtask

   task automatic t_add();
      u_mem.prog[0] = 16'h2302;
      u_mem.prog[1] = 16'h2085;
      u_mem.ram[12'h202] = 8'h02;
      u_mem.ram[12'hF85] = 8'h7F;
      wr(REG_BANK, 8'h02);
      wr(REG_WORK, 8'h4D);
      wr(REG_STATUS, 8'h01);
      run(21'h0, 2);
      check("file reads", 2, re_seen);
      check("file writes", 1, we_seen);
      check("file 202", 8'h50, u_mem.ram[12'h202]);
      check("file F85", 8'h7F, u_mem.ram[12'hF85]);
      rd(REG_WORK, 8'hCC, "work after add");
      rd(REG_STATUS, 8'h1A, "status after add");
      check_pc(21'h4);
   endtask

   task automatic t_and();
      u_mem.prog[0] = 16'h0BF3;
      u_mem.prog[1] = 16'h1710;
      u_mem.prog[2] = 16'h0B5C;
      u_mem.ram[12'h210] = 8'hC6;
      wr(REG_WORK, 8'hA3);
      wr(REG_STATUS, 8'h09);
      run(21'h0, 3);
      check("file 210", 8'h82, u_mem.ram[12'h210]);
      rd(REG_WORK, 8'h00, "work after and");
      rd(REG_STATUS, 8'h0D, "status after and");
   endtask

   task automatic t_bits();
      for (int b = 0; b < 8; b++) begin
         u_mem.prog[b] = {4'h9, 3'(b), 1'b1, 8'(8'h20 + b)};
         u_mem.prog[b + 8] = {4'h8, 3'(b), 1'b1, 8'(8'h30 + b)};
         u_mem.ram[12'h220 + b] = 8'hFF;
         u_mem.ram[12'h230 + b] = 8'h00;
      end
      wr(REG_STATUS, 8'h1F);
      run(21'h0, 16);
      check("bit op writes", 16, we_seen);
      for (int b = 0; b < 8; b++) begin
         // Byte-wide mask, else the inverse fills the upper compare bits
         check("cleared bit", 8'(~(8'h01 << b)),
            u_mem.ram[12'h220 + b]);
         check("set bit", 8'(8'h01 << b),
            u_mem.ram[12'h230 + b]);
      end
      rd(REG_STATUS, 8'h1F, "status after bit ops");
      check_pc(21'h20);
   endtask

   task automatic t_index();
      u_mem.prog[0] = {4'h8, 3'd7, 1'b0, 8'h5F};
      u_mem.prog[1] = {4'h8, 3'd0, 1'b0, 8'h60};
      u_mem.prog[2] = {4'h9, 3'd1, 1'b0, 8'h81};
      u_mem.ram[12'h35F] = 8'h00;
      u_mem.ram[12'h060] = 8'h00;
      u_mem.ram[12'hF81] = 8'hFF;
      idx_base <= 12'h300;
      ext = 8'h02;
      run(21'h0, 3);
      ext = 8'h00;
      check("indexed byte", 8'h80, u_mem.ram[12'h35F]);
      check("access low", 8'h01, u_mem.ram[12'h060]);
      check("access high", 8'hFD, u_mem.ram[12'hF81]);
   endtask

   task automatic br(input logic [15:0] word, input int n,
                     input logic [7:0] st, input bit tk);
      logic [20:0] tgt;
      tgt = tk ? 21'(66 + 2 * n) : 21'h42;
      u_mem.prog[8'h20] = word;
      u_mem.prog[8'h21] = 16'h0B00;
      wr(REG_WORK, 8'h5A);
      wr(REG_STATUS, st);
      run(21'h40, tk ? 2 : 1);
      check("branch file reads", 0, re_seen);
      check("branch file writes", 0, we_seen);
      rd(REG_WORK, 8'h5A, "work after branch");
      rd(REG_STATUS, st, "status after branch");
      check_pc(tgt);
   endtask

   task automatic t_branches();
      logic [7:0] fl [4];
      logic [7:0] st;
      int n;
      fl = '{8'h04, 8'h01, 8'h08, 8'h10};
      for (int cc = 0; cc < 8; cc++) begin
         for (int v = 0; v < 2; v++) begin
            st = (v == 1) ? fl[cc / 2] : 8'h00;
            n = (cc % 4 < 2) ? -128 : 127;
            br({8'(8'hE0 + cc), 8'(n)}, n, st,
               (v == 1) ^ cc[0]);
         end
      end
      br({5'h1A, 11'h3FF}, 1023, 8'h1F, 1'b1);
      br({5'h1A, 11'h400}, -1024, 8'h00, 1'b1);
   endtask

   initial begin
      resetn = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 8'h00;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      idx_base = 12'h000;
      ext = 8'h00;
      watch = 1'b0;
      repeat (2) @(posedge sys_clk);
      resetn <= 1'b1;
      t_reset();
      t_add();
      t_and();
      t_bits();
      t_index();
      t_branches();
      summarize();
   end
endmodule
